// ---- rtl/baud_if.sv ----
`timescale 1ns/1ps
interface baud_if #(parameter int DIV_W = 16);
   logic [DIV_W-1:0] divisor;
   logic             run;
   logic             tick;
   modport gen  (input divisor, input run, output tick);
   modport user (output divisor, output run, input tick);
endinterface

// ---- rtl/baud_tick_gen.sv ----
`timescale 1ns/1ps
module baud_tick_gen #(
   parameter int DIV_W = 16
) (
   input  wire logic clk_sys_in,
   input  wire logic rst_in,
   baud_if.gen       baud
);
   logic [DIV_W-1:0] count_q;
   logic             tick_q;

   // one-cycle tick every divisor+1 cycles while running
   always_ff @(posedge clk_sys_in) begin
      if (rst_in || !baud.run) begin
         count_q <= '0;
         tick_q  <= 1'b0;
      end else if (count_q >= baud.divisor) begin
         count_q <= '0;
         tick_q  <= 1'b1;
      end else begin
         count_q <= count_q + {{(DIV_W-1){1'b0}}, 1'b1};
         tick_q  <= 1'b0;
      end
   end

   assign baud.tick = tick_q;
endmodule

// ---- rtl/bitbang_cfg.svh ----
// Overview of operation
// [RL1] code 0x01 selects asynchronous bit-bang
// [RL2] strobes driven out in asynchronous mode
// [RL3] host bytes go onto output pins
// [RL4] each pin direction chosen individually
// [RL5] baud tick paces output pin updates
// [RL6] outputs hold last value without new byte
// [RL7] code 0x04 selects synchronous bit-bang
// [RL8] sync outputs change per byte, write strobe
// [RL9] sync sample returned only after byte write
// [RL10] sync stalls while return buffer full
// [RL11] pins sampled before new byte driven
// [RL12] host sends extra byte for last sample
// [RL13] read strobe high, low, setup, write pulse
// [RL14] read strobe rise marks sample handed over
// [RL15] setup mask sets directions until next setup
// [RL16] host writes bytes even when all inputs
// [RL17] code 0x02 selects serial engine mode
// [RL18] code 0x00 resets port mode
// [RL19] after reset pins inputs, strobes inactive
`ifndef BITBANG_CFG_SVH
`define BITBANG_CFG_SVH

`define BB_ADDR_W        8
`define BB_OFS_MODE      8'h00
`define BB_OFS_DATA      8'h04
`define BB_OFS_SAMPLE    8'h08
`define BB_OFS_STATUS    8'h0c
`define BB_OFS_BAUD      8'h10

`define BB_CODE_RESET    8'h00
`define BB_CODE_ASYNC    8'h01
`define BB_CODE_SERIAL   8'h02
`define BB_CODE_SYNC     8'h04

`define BB_MODE_CODE_LSB 0
`define BB_MODE_CODE_MSB 7
`define BB_MODE_MASK_LSB 8
`define BB_MODE_MASK_MSB 15

`define BB_ST_MODE_LSB   0
`define BB_ST_MODE_MSB   1
`define BB_ST_PEND_BIT   2
`define BB_ST_SVAL_BIT   3
`define BB_ST_MASK_LSB   8
`define BB_ST_MASK_MSB   15
`define BB_ST_PINS_LSB   16
`define BB_ST_PINS_MSB   23

`define BB_MASK_RST      8'h00
`define BB_OUT_RST       8'h00
`define BB_BAUD_RST      16'h0009
`define BB_SETUP_CYCLES  1

`endif

// ---- rtl/bitbang_pkg.sv ----
package bitbang_pkg;
   typedef enum logic [1:0] {
      MODE_RESET,
      MODE_ASYNC,
      MODE_SERIAL,
      MODE_SYNC
   } mode_e;

   typedef enum logic [2:0] {
      SS_IDLE,
      SS_READ,
      SS_DRIVE,
      SS_SETUP,
      SS_WRITE
   } sync_state_e;
endpackage

// ---- rtl/bitbang_port.sv ----
// Our own choices: the register offsets and register access over APB.
`timescale 1ns/1ps
`include "bitbang_cfg.svh"
module bitbang_port #(
   parameter int PORT_W = 8,
   parameter int DIV_W  = 16
) (
   input  wire logic              clk_sys_in,
   input  wire logic              rst_in,
   input  wire logic              psel_in,
   input  wire logic              penable_in,
   input  wire logic              pwrite_in,
   input  wire logic [7:0]        paddr_in,
   input  wire logic [31:0]       pwdata_in,
   output logic [31:0]            prdata_out,
   output logic                   pready_out,
   output logic                   pslverr_out,
   input  wire logic [PORT_W-1:0] port_in,
   output logic [PORT_W-1:0]      port_out,
   output logic [PORT_W-1:0]      port_oe_n_out,
   output logic                   read_strobe_n_out,
   output logic                   write_strobe_n_out
);
   ////////////////////////////////////////////////////////////////////////////
   bitbang_pkg::mode_e       mode_q;
   bitbang_pkg::sync_state_e state_q;
   logic [PORT_W-1:0]        mask_q;
   logic [PORT_W-1:0]        out_q;
   logic [PORT_W-1:0]        data_q;
   logic                     pending_q;
   logic [PORT_W-1:0]        sample_q;
   logic                     sample_valid_q;
   logic [DIV_W-1:0]         divisor_q;
   logic                     rd_n_q;
   logic                     wr_n_q;
   logic [PORT_W-1:0]        pin_ff1_q;
   logic [PORT_W-1:0]        pin_ff2_q;
   logic [PORT_W-1:0]        pin_ff3_q;
   logic [PORT_W-1:0]        pins_q;
   logic [31:0]              prdata_q;
   logic                     rd_done_q;
   logic                     access;
   logic                     wr_ok;
   logic                     rd_ok;
   logic                     mapped;
   logic                     mode_wr;
   logic                     data_wr;
   logic                     sample_rd;
   logic                     code_ok;
   bitbang_pkg::mode_e       code_mode;
   logic                     async_load;

   baud_if #(.DIV_W(DIV_W)) baud ();

   baud_tick_gen #(.DIV_W(DIV_W)) u_baud (
      .clk_sys_in (clk_sys_in),
      .rst_in     (rst_in),
      .baud       (baud.gen)
   );

   assign baud.divisor = divisor_q;
   assign baud.run     = (mode_q == bitbang_pkg::MODE_ASYNC);

   function automatic logic code_valid(input logic [7:0] code);
      return (code == `BB_CODE_RESET) || (code == `BB_CODE_ASYNC) ||
             (code == `BB_CODE_SERIAL) || (code == `BB_CODE_SYNC);
   endfunction

   function automatic bitbang_pkg::mode_e code_to_mode(input logic [7:0] code);
      bitbang_pkg::mode_e m;
      m = bitbang_pkg::MODE_RESET;
      if (code == `BB_CODE_ASYNC) begin
         m = bitbang_pkg::MODE_ASYNC;
      end else if (code == `BB_CODE_SERIAL) begin
         m = bitbang_pkg::MODE_SERIAL;
      end else if (code == `BB_CODE_SYNC) begin
         m = bitbang_pkg::MODE_SYNC;
      end
      return m;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // apb decode; data writes wait while the previous byte is still pending
   assign access    = psel_in && penable_in;
   assign mapped    = (paddr_in == `BB_OFS_MODE) || (paddr_in == `BB_OFS_DATA) ||
                      (paddr_in == `BB_OFS_SAMPLE) || (paddr_in == `BB_OFS_STATUS) ||
                      (paddr_in == `BB_OFS_BAUD);
   assign wr_ok     = !(paddr_in == `BB_OFS_DATA && pending_q);
   assign rd_ok     = rd_done_q;
   assign pready_out = pwrite_in ? wr_ok : rd_ok;
   assign pslverr_out = access && pready_out && !mapped;
   assign mode_wr   = access && pwrite_in && paddr_in == `BB_OFS_MODE;
   assign data_wr   = access && pwrite_in && wr_ok && paddr_in == `BB_OFS_DATA;
   assign sample_rd = access && !pwrite_in && rd_done_q && paddr_in == `BB_OFS_SAMPLE;
   assign code_ok   = code_valid(pwdata_in[`BB_MODE_CODE_MSB:`BB_MODE_CODE_LSB]);
   assign code_mode = code_to_mode(pwdata_in[`BB_MODE_CODE_MSB:`BB_MODE_CODE_LSB]);
   assign prdata_out = prdata_q;

   // reads answer on the second access cycle from a registered word
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         rd_done_q <= 1'b0;
         prdata_q  <= 32'h0000_0000;
      end else begin
         rd_done_q <= access && !pwrite_in && !rd_done_q;
         if (access && !pwrite_in && !rd_done_q) begin
            prdata_q <= 32'h0000_0000;
            unique case (paddr_in)
               `BB_OFS_MODE: begin
                  prdata_q[`BB_MODE_MASK_MSB:`BB_MODE_MASK_LSB] <= mask_q;
               end
               `BB_OFS_DATA: begin
                  prdata_q[PORT_W-1:0] <= out_q;
               end
               `BB_OFS_SAMPLE: begin
                  prdata_q[PORT_W-1:0] <= sample_q;
               end
               `BB_OFS_STATUS: begin
                  prdata_q[`BB_ST_MODE_MSB:`BB_ST_MODE_LSB] <= mode_q;
                  prdata_q[`BB_ST_PEND_BIT] <= pending_q;
                  prdata_q[`BB_ST_SVAL_BIT] <= sample_valid_q;
                  prdata_q[`BB_ST_MASK_MSB:`BB_ST_MASK_LSB] <= mask_q;
                  prdata_q[`BB_ST_PINS_MSB:`BB_ST_PINS_LSB] <= pins_q;
               end
               `BB_OFS_BAUD: begin
                  prdata_q[DIV_W-1:0] <= divisor_q;
               end
               default: begin
                  prdata_q <= 32'h0000_0000;
               end
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // mode and direction set by the same setup word; bad codes are ignored
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         mode_q <= bitbang_pkg::MODE_RESET;
         mask_q <= `BB_MASK_RST;
      end else if (mode_wr && code_ok) begin
         mode_q <= code_mode; // RL1 RL7 RL17 RL18
         mask_q <= pwdata_in[`BB_MODE_MASK_MSB:`BB_MODE_MASK_LSB]; // RL15
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         divisor_q <= DIV_W'(`BB_BAUD_RST);
      end else if (access && pwrite_in && paddr_in == `BB_OFS_BAUD) begin
         divisor_q <= pwdata_in[DIV_W-1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // pin synchroniser: accept once second and third stage agree
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         pin_ff1_q <= '0;
         pin_ff2_q <= '0;
         pin_ff3_q <= '0;
         pins_q    <= '0;
      end else begin
         pin_ff1_q <= port_in;
         pin_ff2_q <= pin_ff1_q;
         pin_ff3_q <= pin_ff2_q;
         if (pin_ff2_q == pin_ff3_q) begin
            pins_q <= pin_ff3_q;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // byte from the host, one deep
   assign async_load = (mode_q == bitbang_pkg::MODE_ASYNC) && baud.tick && pending_q;

   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         pending_q <= 1'b0;
         data_q    <= '0;
      end else if (mode_wr && code_ok) begin
         pending_q <= 1'b0;
      end else if (data_wr) begin
         pending_q <= 1'b1;
         data_q    <= pwdata_in[PORT_W-1:0];
      end else if (async_load || state_q == bitbang_pkg::SS_DRIVE) begin
         pending_q <= 1'b0;
      end
   end

   // sample towards the host; a new sample wins over a clearing read
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         sample_valid_q <= 1'b0;
         sample_q       <= '0;
      end else if (state_q == bitbang_pkg::SS_READ) begin
         sample_valid_q <= 1'b1; // RL9 RL14
         sample_q       <= pins_q; // RL11
      end else if (sample_rd || (mode_wr && code_ok)) begin
         sample_valid_q <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // synchronous transfer sequence
   always_ff @(posedge clk_sys_in) begin
      if (rst_in || (mode_wr && code_ok) || mode_q != bitbang_pkg::MODE_SYNC) begin
         state_q <= bitbang_pkg::SS_IDLE;
      end else begin
         unique case (state_q)
            bitbang_pkg::SS_IDLE: begin
               if (pending_q && !sample_valid_q) begin
                  state_q <= bitbang_pkg::SS_READ; // RL10
               end
            end
            bitbang_pkg::SS_READ: begin
               state_q <= bitbang_pkg::SS_DRIVE;
            end
            bitbang_pkg::SS_DRIVE: begin
               state_q <= bitbang_pkg::SS_SETUP;
            end
            bitbang_pkg::SS_SETUP: begin
               state_q <= bitbang_pkg::SS_WRITE; // RL13
            end
            bitbang_pkg::SS_WRITE: begin
               state_q <= bitbang_pkg::SS_IDLE;
            end
            default: begin
               state_q <= bitbang_pkg::SS_IDLE;
            end
         endcase
      end
   end

   // output latch: async on a tick, sync in the drive step
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         out_q <= `BB_OUT_RST;
      end else if (async_load) begin
         out_q <= data_q; // RL3 RL5
      end else if (state_q == bitbang_pkg::SS_DRIVE) begin
         out_q <= data_q; // RL8
      end
   end

   // strobes, active low
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         rd_n_q <= 1'b1;
         wr_n_q <= 1'b1;
      end else begin
         unique case (mode_q)
            bitbang_pkg::MODE_ASYNC: begin
               rd_n_q <= !baud.tick; // RL2
               wr_n_q <= !async_load; // RL2
            end
            bitbang_pkg::MODE_SYNC: begin
               rd_n_q <= (state_q == bitbang_pkg::SS_IDLE) && pending_q &&
                         !sample_valid_q ? 1'b1 : 1'b0; // RL13 RL14
               wr_n_q <= (state_q != bitbang_pkg::SS_SETUP); // RL13
            end
            default: begin
               rd_n_q <= 1'b1; // RL19
               wr_n_q <= 1'b1;
            end
         endcase
      end
   end

   assign read_strobe_n_out  = rd_n_q;
   assign write_strobe_n_out = wr_n_q;
   assign port_out           = out_q; // RL6
   assign port_oe_n_out      = (mode_q == bitbang_pkg::MODE_ASYNC ||
                                mode_q == bitbang_pkg::MODE_SYNC) ? ~mask_q : '1; // RL4 RL19

   ////////////////////////////////////////////////////////////////////////////
   async_enter_a: assert property ( // RL1
      @(posedge clk_sys_in) disable iff (rst_in)
      mode_wr && pwdata_in[`BB_MODE_CODE_MSB:`BB_MODE_CODE_LSB] == `BB_CODE_ASYNC
      |=> mode_q == bitbang_pkg::MODE_ASYNC)
      else $error("async code did not select async mode");

   sync_enter_a: assert property ( // RL7
      @(posedge clk_sys_in) disable iff (rst_in)
      mode_wr && pwdata_in[`BB_MODE_CODE_MSB:`BB_MODE_CODE_LSB] == `BB_CODE_SYNC
      |=> mode_q == bitbang_pkg::MODE_SYNC)
      else $error("sync code did not select sync mode");

   serial_enter_a: assert property ( // RL17
      @(posedge clk_sys_in) disable iff (rst_in)
      mode_wr && pwdata_in[`BB_MODE_CODE_MSB:`BB_MODE_CODE_LSB] == `BB_CODE_SERIAL
      |=> mode_q == bitbang_pkg::MODE_SERIAL)
      else $error("serial code did not select serial engine mode");

   mode_reset_a: assert property ( // RL18
      @(posedge clk_sys_in) disable iff (rst_in)
      mode_wr && pwdata_in[`BB_MODE_CODE_MSB:`BB_MODE_CODE_LSB] == `BB_CODE_RESET
      |=> mode_q == bitbang_pkg::MODE_RESET &&
      port_oe_n_out == '1)
      else $error("reset code did not leave bit-bang mode");

   async_drive_a: assert property ( // RL3
      @(posedge clk_sys_in) disable iff (rst_in)
      async_load && !mode_wr |=> port_out == $past(data_q) && !write_strobe_n_out)
      else $error("async byte not driven with write strobe");

   output_hold_a: assert property ( // RL5
      @(posedge clk_sys_in) disable iff (rst_in)
      !async_load && state_q != bitbang_pkg::SS_DRIVE |=> $stable(port_out))
      else $error("output pins changed without a pacing event");

   dir_mask_a: assert property ( // RL4
      @(posedge clk_sys_in) disable iff (rst_in)
      mode_q == bitbang_pkg::MODE_SYNC |-> port_oe_n_out == ~mask_q)
      else $error("pin directions do not follow mask");

   sync_sequence_a: assert property ( // RL13
      @(posedge clk_sys_in) disable iff (rst_in)
      state_q == bitbang_pkg::SS_READ && mode_q == bitbang_pkg::MODE_SYNC && !mode_wr
      |-> read_strobe_n_out ##1 !read_strobe_n_out
      ##1 write_strobe_n_out && port_out == $past(data_q)
      ##1 !write_strobe_n_out ##1 write_strobe_n_out)
      else $error("sync strobe sequence wrong");

   read_rise_a: assert property ( // RL14
      @(posedge clk_sys_in) disable iff (rst_in)
      $rose(read_strobe_n_out) && mode_q == bitbang_pkg::MODE_SYNC &&
      $past(mode_q) == bitbang_pkg::MODE_SYNC
      |=> sample_valid_q)
      else $error("read strobe rise without sample");

   sample_first_a: assert property ( // RL11
      @(posedge clk_sys_in) disable iff (rst_in)
      state_q == bitbang_pkg::SS_READ |=> sample_q == $past(pins_q) &&
      $stable(port_out))
      else $error("sample not taken before drive");

   stall_full_a: assert property ( // RL10
      @(posedge clk_sys_in) disable iff (rst_in)
      state_q == bitbang_pkg::SS_IDLE && sample_valid_q |=> state_q == bitbang_pkg::SS_IDLE)
      else $error("sync transfer ran with return buffer full");

   sample_cause_a: assert property ( // RL9
      @(posedge clk_sys_in) disable iff (rst_in)
      $rose(sample_valid_q) |-> $past(state_q) == bitbang_pkg::SS_READ)
      else $error("sample appeared without a byte");

   idle_safe_a: assert property ( // RL19
      @(posedge clk_sys_in) disable iff (rst_in)
      mode_q == bitbang_pkg::MODE_RESET |=> port_oe_n_out == '1 ||
      mode_q != bitbang_pkg::MODE_RESET)
      else $error("pins driven while no bit-bang mode");
endmodule

// ---- tb/bitbang_port_tb.sv ----
`timescale 1ns/1ps
`include "bitbang_cfg.svh"
module bitbang_port_tb;
   logic        clk_sys_in = 1'b0;
   logic        rst_in     = 1'b1;
   logic        psel       = 1'b0;
   logic        penable    = 1'b0;
   logic        pwrite     = 1'b0;
   logic [7:0]  paddr      = 8'h00;
   logic [31:0] pwdata     = 32'h0;
   logic [7:0]  ext        = 8'h00;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [7:0]  pins;
   logic [7:0]  port_drv;
   logic [7:0]  oe_n;
   logic        rd_n;
   logic        wr_n;
   logic [7:0]  wr_dat;
   int          wr_cnt;
   int          rd_cnt;
   int          wr_gap;
   int          failures = 0;
   int          check_count = 0;

   always #50 clk_sys_in = ~clk_sys_in;

   bitbang_port dut (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .psel_in(psel),
      .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
      .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .port_in(pins),
      .port_out(port_drv), .port_oe_n_out(oe_n), .read_strobe_n_out(rd_n),
      .write_strobe_n_out(wr_n));

   strobe_logic far (.clk_sys_in(clk_sys_in), .port_drv_in(port_drv), .oe_n_in(oe_n),
      .read_strobe_n_in(rd_n), .write_strobe_n_in(wr_n), .ext_in(ext), .pins_out(pins),
      .wr_count_out(wr_cnt), .rd_count_out(rd_cnt), .wr_gap_out(wr_gap),
      .wr_data_out(wr_dat));

   ////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         failures++;
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
   endtask

   // one apb transfer; request held until pready is seen high at a rising edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
      @(posedge clk_sys_in);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk_sys_in);
      penable <= 1'b1;
      @(posedge clk_sys_in iff pready);
      r = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic        e;
      apb(1'b1, a, d, r, e);
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] r);
      logic e;
      apb(1'b0, a, 32'h0, r, e);
   endtask

   task automatic mode(input logic [7:0] code, input logic [7:0] mask);
      wr(`BB_OFS_MODE, {16'h0, mask, code});
   endtask

   task automatic set_ext(input logic [7:0] v);
      @(posedge clk_sys_in);
      ext <= v;
   endtask

   task automatic settle(input int n);
      repeat (n) @(posedge clk_sys_in);
      @(negedge clk_sys_in);
   endtask

   // poll until a sample is waiting, then fetch it
   task automatic get_sample(output logic [31:0] s);
      for (int n = 0; n < 30; n++) begin
         rd(`BB_OFS_STATUS, s);
         if (s[`BB_ST_SVAL_BIT] === 1'b1) break;
      end
      rd(`BB_OFS_SAMPLE, s);
   endtask

   ////////////////////////////////////////////////////////////
   task automatic t_reset();
      logic [31:0] r;
      logic        e;
      settle(1);
      chk(oe_n, 8'hff);
      chk({rd_n, wr_n}, 2'b11);
      rd(`BB_OFS_BAUD, r);
      chk(r, 32'h9);
      apb(1'b0, 8'h20, 32'h0, r, e);
      chk(e, 1'b1);
      chk(r, 32'h0);
      $display("test reset done");
   endtask

   task automatic t_modes();
      logic [7:0]  code [4] = '{8'h01, 8'h02, 8'h04, 8'h00};
      logic [1:0]  st [4]   = '{2'd1, 2'd2, 2'd3, 2'd0};
      logic [7:0]  oe [4]   = '{8'hf0, 8'hff, 8'hf0, 8'hff};
      logic [31:0] s;
      for (int i = 0; i < 4; i++) begin
         mode(code[i], 8'h0f);
         rd(`BB_OFS_STATUS, s);
         chk(s[1:0], st[i]);
         rd(`BB_OFS_MODE, s);
         chk(s[15:8], 8'h0f);
         settle(0);
         chk(oe_n, oe[i]);
         if (i == 1) chk({rd_n, wr_n}, 2'b11);
      end
      mode(8'h03, 8'hff);
      rd(`BB_OFS_STATUS, s);
      chk(s[1:0], 2'd0);
      rd(`BB_OFS_MODE, s);
      chk(s[15:8], 8'h0f);
      $display("test modes done");
   endtask

   task automatic t_async();
      int c0;
      int r0;
      set_ext(8'h90);
      mode(`BB_CODE_ASYNC, 8'h0f);
      wr(`BB_OFS_BAUD, 32'd40);
      c0 = wr_cnt;
      r0 = rd_cnt;
      wr(`BB_OFS_DATA, 32'ha5);
      wr(`BB_OFS_DATA, 32'h3c);
      for (int n = 0; n < 200 && wr_cnt < c0 + 2; n++) @(posedge clk_sys_in);
      chk(wr_gap, 41);
      settle(60);
      chk(pins, 8'h9c);
      chk(wr_cnt - c0, 2);
      chk(wr_dat, 8'h9c);
      chk(rd_cnt - r0 > 1, 1);
      $display("test async done");
   endtask

   task automatic t_sync();
      logic [7:0]  snd [4] = '{8'hff, 8'h55, 8'haa, 8'haa};
      logic [7:0]  exp [4] = '{8'h3c, 8'hff, 8'h55, 8'haa};
      logic [31:0] s;
      int          c0;
      int          r0;
      mode(`BB_CODE_SYNC, 8'hff);
      c0 = wr_cnt;
      r0 = rd_cnt;
      settle(20);
      chk(rd_cnt - r0, 0);
      for (int i = 0; i < 4; i++) begin
         wr(`BB_OFS_DATA, {24'h0, snd[i]});
         get_sample(s);
         chk(s[7:0], exp[i]);
      end
      chk(wr_cnt - c0, 4);
      chk(rd_cnt - r0, 4);
      chk(wr_dat, 8'haa);
      wr(`BB_OFS_DATA, 32'h11);
      wr(`BB_OFS_DATA, 32'h22);
      settle(20);
      chk(port_drv, 8'h11);
      rd(`BB_OFS_STATUS, s);
      chk(s[`BB_ST_PEND_BIT], 1'b1);
      rd(`BB_OFS_SAMPLE, s);
      chk(s[7:0], 8'haa);
      get_sample(s);
      chk(s[7:0], 8'h11);
      settle(0);
      chk(port_drv, 8'h22);
      $display("test sync done");
   endtask

   task automatic t_inputs();
      logic [31:0] s;
      set_ext(8'h3c);
      mode(`BB_CODE_SYNC, 8'h00);
      wr(`BB_OFS_DATA, 32'hc3);
      get_sample(s);
      chk(s[7:0], 8'h3c);
      rd(`BB_OFS_STATUS, s);
      chk(s[`BB_ST_PINS_MSB:`BB_ST_PINS_LSB], 8'h3c);
      settle(0);
      chk(pins, 8'h3c);
      mode(`BB_CODE_RESET, 8'hff);
      settle(2);
      chk(oe_n, 8'hff);
      $display("test inputs done");
   endtask

   ////////////////////////////////////////////////////////////
   task automatic wrap_up();
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   initial begin
      repeat (8) @(posedge clk_sys_in);
      rst_in <= 1'b0;
      t_reset();
      t_modes();
      t_async();
      t_sync();
      t_inputs();
      wrap_up();
   end

   initial begin
      #3000000;
      failures++;
      wrap_up();
   end
endmodule

// ---- tb/strobe_logic.sv ----
`timescale 1ns/1ps
module strobe_logic (
   input  wire logic       clk_sys_in,
   input  wire logic [7:0] port_drv_in,
   input  wire logic [7:0] oe_n_in,
   input  wire logic       read_strobe_n_in,
   input  wire logic       write_strobe_n_in,
   input  wire logic [7:0] ext_in,
   output logic [7:0]      pins_out,
   output int              wr_count_out,
   output int              rd_count_out,
   output int              wr_gap_out,
   output logic [7:0]      wr_data_out
);
   logic rd_q = 1'b1;
   logic wr_q = 1'b1;
   int   cyc = 0;
   int   wr_last = 0;
   initial begin
      wr_count_out = 0;
      rd_count_out = 0;
      wr_gap_out   = 0;
      wr_data_out  = 8'h00;
   end
   // a pin shows the port only while its enable is low, else the outside logic drives it
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         pins_out[i] = oe_n_in[i] ? ext_in[i] : port_drv_in[i];
      end
   end
   // outside logic samples the strobes on clk_sys_in: latch pins on write rise, count edges
   always @(posedge clk_sys_in) begin
      rd_q <= read_strobe_n_in;
      wr_q <= write_strobe_n_in;
      cyc  <= cyc + 1;
      if (rd_q === 1'b0 && read_strobe_n_in === 1'b1) begin
         rd_count_out <= rd_count_out + 1;
      end
      if (wr_q === 1'b1 && write_strobe_n_in === 1'b0) begin
         wr_count_out <= wr_count_out + 1;
         wr_gap_out   <= cyc - wr_last;
         wr_last      <= cyc;
      end
      if (wr_q === 1'b0 && write_strobe_n_in === 1'b1) begin
         wr_data_out <= pins_out;
      end
   end
endmodule
